// ### verilog/mac_slice_pkg.sv
// What this block does
// - Count bad-check frames with whole-octet length.
// - Reading counter clears it unless low lanes off.
// - Only receive events, reads and writes change the error counter.
// - Transmitter waits at least programmed nibble gap.
// - Gap field is gap minus three or six.
// - Accept 16/32-bit writes, ignore 8-bit ones.
// - Station octet six high, octet five low.
// - Station octets load from nonvolatile value.
// - Gap register upper bits read zero.
package mac_slice_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses).
  // ---------------------------------------------------------------
  localparam logic [7:0] CRC_ERR_OFS  = 8'h00; // Error statistics.
  localparam logic [7:0] GAP_OFS      = 8'h10; // Back-to-back gap.
  localparam logic [7:0] STATION_OFS  = 8'h20; // Station octets 5/6.
  localparam logic [7:0] INT_STAT_OFS = 8'h30; // Sticky events, W1C.
  localparam logic [7:0] INT_MASK_OFS = 8'h34; // Interrupt mask.
  localparam logic [7:0] MODE_OFS     = 8'h38; // Duplex mode.

  // Alias offsets added to a register's base address.
  localparam logic [3:0] ALIAS_CLR_OFS = 4'h4;
  localparam logic [3:0] ALIAS_SET_OFS = 4'h8;
  localparam logic [3:0] ALIAS_INV_OFS = 4'hC;

  // ---------------------------------------------------------------
  // Field layouts and reset values.
  // ---------------------------------------------------------------
  localparam int          CNT_W        = 16;    // Error counter width.
  localparam int          GAP_W        = 7;     // Gap field width.
  localparam logic [6:0]  GAP_RESET    = 7'h12; // Gap field reset.
  localparam logic [3:0]  FULL_DUP_ADD = 4'h3;  // Full duplex offset.
  localparam logic [3:0]  HALF_DUP_ADD = 4'h6;  // Half duplex offset.
  localparam int          INT_W        = 2;     // Interrupt bits.
  localparam int          INT_CRC_BIT  = 0;     // Counted error.
  localparam int          INT_WRAP_BIT = 1;     // Counter rollover.
  localparam int          MODE_FD_BIT  = 0;     // 1 = full duplex.

  // ---------------------------------------------------------------
  // Timing.
  // ---------------------------------------------------------------
  localparam int CLK_NS    = 100; // Clock period.
  localparam int NIBBLE_NS = 400; // Nibble time at 10 Mbps.
  localparam int NIBBLE_CYCLES =
    (NIBBLE_NS / CLK_NS < 1) ? 1 : NIBBLE_NS / CLK_NS;

  // ---------------------------------------------------------------
  // Types.
  // ---------------------------------------------------------------
  // Kind of register write, chosen by the alias address.
  typedef enum logic [1:0] {
    WR_PLAIN = 2'b00,
    WR_CLR   = 2'b01,
    WR_SET   = 2'b10,
    WR_INV   = 2'b11
  } wr_op_e;

  // One received frame's verdict from the receive path.
  typedef struct packed {
    logic       done;    // One-cycle end-of-frame pulse.
    logic       fcsBad;  // Check sequence mismatched.
    logic [2:0] bitsMod; // Frame length in bits, modulo eight.
  } rx_frame_s;

  // Transmit path framing strobes.
  typedef struct packed {
    logic start; // First nibble of a packet leaves.
    logic stop;  // Last nibble of a packet has left.
  } tx_frame_s;

endpackage : mac_slice_pkg

// ### verilog/rx_crc_err_counter.sv
`timescale 1ns/1ps
// Receive check-sequence error counter with alias writes.
module rx_crc_err_counter (
  input  wire logic                             clk,
  input  wire logic                             srst,
  input  wire mac_slice_pkg::rx_frame_s         rxFrame,
  input  wire logic                             readClear,
  input  wire logic                             wrEn,
  input  wire mac_slice_pkg::wr_op_e            wrOp,
  input  wire logic [mac_slice_pkg::CNT_W-1:0]  wrData,
  input  wire logic [mac_slice_pkg::CNT_W-1:0]  wrMask,
  output logic      [mac_slice_pkg::CNT_W-1:0]  count,
  output logic                                  countEvt,
  output logic                                  wrapEvt
);

  // Qualifying receive event; transmit signals never reach here.
  logic countHit; // Bad frame of whole octets.
  assign countHit = rxFrame.done && rxFrame.fcsBad
                    && (rxFrame.bitsMod == 3'h0);

  // ---------------------------------------------------------------
  // Counter update.
  // ---------------------------------------------------------------
  // Software effects are applied first and the event added after,
  // so a frame in the cycle of a clear is never lost.
  always_ff @(posedge clk) begin
    logic [mac_slice_pkg::CNT_W-1:0] base;
    base = count;
    if (srst) begin
      count    <= '0;
      countEvt <= 1'b0;
      wrapEvt  <= 1'b0;
    end else begin
      if (readClear) begin
        base = '0;
      end else if (wrEn) begin
        unique case (wrOp)
          mac_slice_pkg::WR_PLAIN:
            base = (count & ~wrMask) | (wrData & wrMask);
          mac_slice_pkg::WR_CLR: base = count & ~(wrData & wrMask);
          mac_slice_pkg::WR_SET: base = count | (wrData & wrMask);
          mac_slice_pkg::WR_INV: base = count ^ (wrData & wrMask);
        endcase
      end
      count    <= base + {{(mac_slice_pkg::CNT_W-1){1'b0}}, countHit};
      countEvt <= countHit;
      wrapEvt  <= countHit && (&base);
    end
  end

endmodule : rx_crc_err_counter

// ### verilog/tx_gap_timer.sv
`timescale 1ns/1ps
// Enforces the minimum gap between back-to-back transmitted packets.
module tx_gap_timer #(
  parameter int NIBBLE_CYCLES = mac_slice_pkg::NIBBLE_CYCLES
) (
  input  wire logic                             clk,
  input  wire logic                             srst,
  input  wire mac_slice_pkg::tx_frame_s         txFrame,
  input  wire logic [mac_slice_pkg::GAP_W-1:0]  gapField,
  input  wire logic                             fullDuplex,
  output logic                                  gapOpen
);

  // Gap states, one-hot.
  typedef enum logic [2:0] {
    GAP_IDLE = 3'b001,
    GAP_TX   = 3'b010,
    GAP_WAIT = 3'b100
  } gap_state_e;

  gap_state_e state;        // Current gap state.
  logic [7:0] nibbleCnt;    // Nibble times elapsed since stop.
  logic [7:0] needNibbles;  // Full gap in nibble times.
  logic [7:0] divCnt;       // Cycle divider for nibble ticks.
  logic       nibbleTick;   // One-cycle pulse per nibble time.

  // Field plus duplex offset gives the true gap length.
  assign needNibbles = {1'b0, gapField}
                       + {4'h0, fullDuplex ? mac_slice_pkg::FULL_DUP_ADD
                                           : mac_slice_pkg::HALF_DUP_ADD};
  assign nibbleTick = (divCnt == 8'(NIBBLE_CYCLES - 1));

  // Nibble divider restarts when a packet ends, aligning the gap.
  always_ff @(posedge clk) begin
    if (srst || txFrame.stop || nibbleTick) begin
      divCnt <= 8'h00;
    end else begin
      divCnt <= divCnt + 8'h01;
    end
  end

  // Gap state machine; the count is re-read each tick, so a
  // reprogrammed field takes effect on the gap in progress.
  always_ff @(posedge clk) begin
    if (srst) begin
      state     <= GAP_IDLE;
      nibbleCnt <= 8'h00;
      gapOpen   <= 1'b1;
    end else begin
      unique case (state)
        GAP_IDLE: begin
          if (txFrame.start) begin
            state   <= GAP_TX;
            gapOpen <= 1'b0;
          end
        end
        GAP_TX: begin
          if (txFrame.stop) begin
            state     <= GAP_WAIT;
            nibbleCnt <= 8'h00;
          end
        end
        GAP_WAIT: begin
          if (nibbleTick) begin
            nibbleCnt <= nibbleCnt + 8'h01;
            if (nibbleCnt + 8'h01 >= needNibbles) begin
              state   <= GAP_IDLE;
              gapOpen <= 1'b1;
            end
          end
        end
      endcase
    end
  end

endmodule : tx_gap_timer

// ### verilog/mac_gap_stats.sv
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ps
// MAC slice: receive error statistics, transmit gap and station
// octets, reached over APB.
module mac_gap_stats #(
  parameter int          NIBBLE_CYCLES = mac_slice_pkg::NIBBLE_CYCLES,
  parameter logic [7:0]  ADDR_W        = 8'd8
) (
  input  wire logic                            clk,
  input  wire logic                            srst,
  // APB slave.
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [7:0]                      paddr,
  input  wire logic [31:0]                     pwdata,
  input  wire logic [3:0]                      pstrb,
  input  wire logic [3:0]                      rdLanes,
  output logic      [31:0]                     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  // Receive and transmit paths.
  input  wire mac_slice_pkg::rx_frame_s        rxFrame,
  input  wire mac_slice_pkg::tx_frame_s        txFrame,
  // Nonvolatile station octets, sampled during reset.
  input  wire logic [15:0]                     stationNv,
  // Results.
  output logic                                 txGapOpen,
  output logic      [7:0]                      stationOctetSix,
  output logic      [7:0]                      stationOctetFive,
  output logic                                 irq
);

  // ---------------------------------------------------------------
  // Register state.
  // ---------------------------------------------------------------
  logic [6:0]  gap_reg;         // Back-to-back gap field.
  logic [15:0] station_reg;     // Octet six high, octet five low.
  logic [1:0]  intStat_reg;     // Sticky events.
  logic [1:0]  intMask_reg;     // Interrupt enables.
  logic        fullDuplex_reg;  // Duplex mode.
  logic [15:0] crcCount;        // Error counter value.
  logic        countEvt;        // A frame was counted.
  logic        wrapEvt;         // Counter rolled over.
  logic        gapOpen;         // Gap timer verdict.

  // ---------------------------------------------------------------
  // Bus decode.
  // ---------------------------------------------------------------
  logic        accStart;   // First access cycle: data is latched.
  logic        accDone;    // Completing access cycle.
  logic [7:0]  regBase;    // Address with alias bits removed.
  logic [3:0]  aliasOfs;   // Alias part of the address.
  mac_slice_pkg::wr_op_e wrOp; // Operation for this address.
  logic        laneOk;     // Write size is 16 or 32 bits.
  logic [31:0] laneMask;   // Write data bits enabled by strobes.
  logic        mapped;     // Address hits a register.
  logic        aliasable;  // Address is a register with aliases.
  logic        wrAccept;   // Write takes effect now.
  logic [31:0] readValue;  // Read data for the current address.

  assign accStart  = psel && penable && !pready;
  assign accDone   = psel && penable && pready;
  assign regBase   = {paddr[7:4], 4'h0};
  assign aliasOfs  = paddr[3:0];
  assign aliasable = (regBase == mac_slice_pkg::CRC_ERR_OFS)
                     || (regBase == mac_slice_pkg::GAP_OFS)
                     || (regBase == mac_slice_pkg::STATION_OFS);

  // Whole halfwords or the whole word only; byte writes are dropped.
  assign laneOk = (pstrb == 4'b1111) || (pstrb == 4'b0011)
                  || (pstrb == 4'b1100);
  assign laneMask = {{8{pstrb[3]}}, {8{pstrb[2]}},
                     {8{pstrb[1]}}, {8{pstrb[0]}}};

  // Alias decode; unknown low address bits count as unmapped.
  always_comb begin
    wrOp   = mac_slice_pkg::WR_PLAIN;
    mapped = 1'b0;
    if (aliasable) begin
      mapped = 1'b1;
      unique case (aliasOfs)
        4'h0: wrOp = mac_slice_pkg::WR_PLAIN;
        mac_slice_pkg::ALIAS_CLR_OFS: wrOp = mac_slice_pkg::WR_CLR;
        mac_slice_pkg::ALIAS_SET_OFS: wrOp = mac_slice_pkg::WR_SET;
        mac_slice_pkg::ALIAS_INV_OFS: wrOp = mac_slice_pkg::WR_INV;
        default: mapped = 1'b0;
      endcase
    end else if (paddr == mac_slice_pkg::INT_STAT_OFS
                 || paddr == mac_slice_pkg::INT_MASK_OFS
                 || paddr == mac_slice_pkg::MODE_OFS) begin
      mapped = 1'b1;
    end
  end

  assign wrAccept = accDone && pwrite && mapped && laneOk;

  // Read multiplexer; unimplemented bits return zero.
  always_comb begin
    readValue = 32'h0000_0000;
    if (paddr == mac_slice_pkg::CRC_ERR_OFS) begin
      readValue = {16'h0000, crcCount};
    end else if (paddr == mac_slice_pkg::GAP_OFS) begin
      readValue = {25'h000_0000, gap_reg};
    end else if (paddr == mac_slice_pkg::STATION_OFS) begin
      readValue = {16'h0000, station_reg};
    end else if (paddr == mac_slice_pkg::INT_STAT_OFS) begin
      readValue = {30'h0000_0000, intStat_reg};
    end else if (paddr == mac_slice_pkg::INT_MASK_OFS) begin
      readValue = {30'h0000_0000, intMask_reg};
    end else if (paddr == mac_slice_pkg::MODE_OFS) begin
      readValue = {31'h0000_0000, fullDuplex_reg};
    end
  end

  // ---------------------------------------------------------------
  // APB handshake.
  // ---------------------------------------------------------------
  // One wait state: data is caught on the first access cycle and
  // handed back with pready on the second, keeping outputs flopped.
  always_ff @(posedge clk) begin
    if (srst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= accStart;
      pslverr <= accStart && !mapped;
      if (accStart && !pwrite) begin
        prdata <= readValue;
      end
    end
  end

  // ---------------------------------------------------------------
  // Error counter.
  // ---------------------------------------------------------------
  // The clear happens on the same edge that latches the read data,
  // so no frame counted in between is lost.
  logic readClear; // Counter is read with a low lane enabled.
  logic crcWrEn;   // Software write to the counter or its aliases.
  assign readClear = accStart && !pwrite
                     && (paddr == mac_slice_pkg::CRC_ERR_OFS)
                     && (rdLanes[1:0] != 2'b00);
  assign crcWrEn   = wrAccept
                     && (regBase == mac_slice_pkg::CRC_ERR_OFS);

  rx_crc_err_counter u_crc (
    .clk       (clk),
    .srst      (srst),
    .rxFrame   (rxFrame),
    .readClear (readClear),
    .wrEn      (crcWrEn),
    .wrOp      (wrOp),
    .wrData    (pwdata[15:0]),
    .wrMask    (laneMask[15:0]),
    .count     (crcCount),
    .countEvt  (countEvt),
    .wrapEvt   (wrapEvt)
  );

  // ---------------------------------------------------------------
  // Alias write helper.
  // ---------------------------------------------------------------
  // Applies a plain, clear, set or invert write under the strobes.
  function automatic logic [15:0] aliasWrite(
    input logic [15:0]          cur,
    input logic [15:0]          data,
    input logic [15:0]          mask,
    input mac_slice_pkg::wr_op_e op
  );
    logic [15:0] hit;
    hit = data & mask;
    unique case (op)
      mac_slice_pkg::WR_PLAIN: aliasWrite = (cur & ~mask) | hit;
      mac_slice_pkg::WR_CLR:   aliasWrite = cur & ~hit;
      mac_slice_pkg::WR_SET:   aliasWrite = cur | hit;
      mac_slice_pkg::WR_INV:   aliasWrite = cur ^ hit;
    endcase
  endfunction : aliasWrite

  // ---------------------------------------------------------------
  // Gap register.
  // ---------------------------------------------------------------
  // Only bits 6:0 store; upper written bits fall away.
  always_ff @(posedge clk) begin
    logic [15:0] gapNext;
    gapNext = aliasWrite({9'h000, gap_reg}, pwdata[15:0],
                         laneMask[15:0], wrOp);
    if (srst) begin
      gap_reg <= mac_slice_pkg::GAP_RESET;
    end else if (wrAccept && regBase == mac_slice_pkg::GAP_OFS) begin
      gap_reg <= gapNext[6:0];
    end
  end

  // ---------------------------------------------------------------
  // Station octets.
  // ---------------------------------------------------------------
  // The reset is synchronous, so the nonvolatile value is taken by
  // a clocked load while reset is held; software may then rewrite.
  always_ff @(posedge clk) begin
    if (srst) begin
      station_reg <= stationNv;
    end else if (wrAccept
                 && regBase == mac_slice_pkg::STATION_OFS) begin
      station_reg <= aliasWrite(station_reg, pwdata[15:0],
                                laneMask[15:0], wrOp);
    end
  end

  // ---------------------------------------------------------------
  // Mode and interrupt registers.
  // ---------------------------------------------------------------
  // Duplex choice selects the gap offset in the timer.
  always_ff @(posedge clk) begin
    if (srst) begin
      fullDuplex_reg <= 1'b1;
      intMask_reg    <= 2'b00;
    end else if (wrAccept) begin
      if (paddr == mac_slice_pkg::MODE_OFS) begin
        fullDuplex_reg <= pwdata[mac_slice_pkg::MODE_FD_BIT];
      end
      if (paddr == mac_slice_pkg::INT_MASK_OFS) begin
        intMask_reg <= pwdata[1:0];
      end
    end
  end

  // Sticky events; a new event wins over a write-one clear.
  always_ff @(posedge clk) begin
    logic [1:0] clr;
    logic [1:0] evt;
    clr = (wrAccept && paddr == mac_slice_pkg::INT_STAT_OFS)
          ? pwdata[1:0] : 2'b00;
    evt = 2'b00;
    evt[mac_slice_pkg::INT_CRC_BIT]  = countEvt;
    evt[mac_slice_pkg::INT_WRAP_BIT] = wrapEvt;
    if (srst) begin
      intStat_reg <= 2'b00;
    end else begin
      intStat_reg <= (intStat_reg & ~clr) | evt;
    end
  end

  // Level interrupt, flopped so it leaves straight from a register.
  always_ff @(posedge clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(intStat_reg & intMask_reg);
    end
  end

  // ---------------------------------------------------------------
  // Transmit gap.
  // ---------------------------------------------------------------
  tx_gap_timer #(
    .NIBBLE_CYCLES (NIBBLE_CYCLES)
  ) u_gap (
    .clk        (clk),
    .srst       (srst),
    .txFrame    (txFrame),
    .gapField   (gap_reg),
    .fullDuplex (fullDuplex_reg),
    .gapOpen    (gapOpen)
  );

  // Result outputs, registered.
  always_ff @(posedge clk) begin
    if (srst) begin
      txGapOpen        <= 1'b1;
      stationOctetSix  <= 8'h00;
      stationOctetFive <= 8'h00;
    end else begin
      txGapOpen        <= gapOpen;
      stationOctetSix  <= station_reg[15:8];
      stationOctetFive <= station_reg[7:0];
    end
  end

endmodule : mac_gap_stats

// ### testbench/mac_gap_stats_asserts.sv
`timescale 1ns/1ps
// Port-level checks of the MAC slice; it sees only the top ports.
module mac_gap_stats_asserts #(
  parameter int NIBBLE_CYCLES = mac_slice_pkg::NIBBLE_CYCLES
) (
  input wire logic                     clk,
  input wire logic                     srst,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [7:0]               paddr,
  input wire logic [31:0]              prdata,
  input wire logic                     pready,
  input wire logic                     pslverr,
  input wire mac_slice_pkg::tx_frame_s txFrame,
  input wire logic [15:0]              stationNv,
  input wire logic                     txGapOpen,
  input wire logic [7:0]               stationOctetSix,
  input wire logic [7:0]               stationOctetFive
);
  // ---------------------------------------------------------------
  // Clocking and helpers.
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic rdDone; // A read completes in this cycle.
  assign rdDone = psel && penable && pready && !pwrite;
  // ---------------------------------------------------------------
  // Properties.
  // ---------------------------------------------------------------
  property p_ready_wait; psel && penable && !pready |=> pready; endproperty
  a_ready_wait: assert property (p_ready_wait)
    else $error("pready did not follow the access cycle");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready stood longer than one cycle");
  property p_err; pslverr |-> pready && (pwrite || prdata == '0); endproperty
  a_err: assert property (p_err)
    else $error("error answer malformed");
  property p_crc_upper;
    rdDone && paddr == mac_slice_pkg::CRC_ERR_OFS |-> prdata[31:16] == '0;
  endproperty
  a_crc_upper: assert property (p_crc_upper)
    else $error("counter read has upper bits set");
  property p_gap_upper;
    rdDone && paddr == mac_slice_pkg::GAP_OFS |-> prdata[31:7] == '0;
  endproperty
  a_gap_upper: assert property (p_gap_upper)
    else $error("gap read has upper bits set");
  property p_station_read;
    rdDone && paddr == mac_slice_pkg::STATION_OFS |->
      prdata == {16'h0000, stationOctetSix, stationOctetFive};
  endproperty
  a_station_read: assert property (p_station_read)
    else $error("station read and octet outputs disagree");
  property p_station_load;
    $fell(srst) |-> ##[0:2] {stationOctetSix, stationOctetFive} == stationNv;
  endproperty
  a_station_load: assert property (p_station_load)
    else $error("station octets not loaded at reset");
  property p_gap_closed; txFrame.start |-> ##3 !txGapOpen; endproperty
  a_gap_closed: assert property (p_gap_closed)
    else $error("gap still open during a packet");
  property p_gap_hold; txFrame.stop |=> !txGapOpen [*3]; endproperty
  a_gap_hold: assert property (p_gap_hold)
    else $error("gap shorter than three nibbles");
endmodule : mac_gap_stats_asserts

bind mac_gap_stats mac_gap_stats_asserts #(
  .NIBBLE_CYCLES(NIBBLE_CYCLES)
) i_mac_gap_stats_asserts (
  .clk, .srst, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .txFrame, .stationNv, .txGapOpen, .stationOctetSix,
  .stationOctetFive
);

// ### testbench/phy_model.sv
`timescale 1ns/1ps
// Far-side stand-in: receive verdicts and transmit framing strobes.
module phy_model (
  input  wire logic               clk,
  input  wire logic               txGapOpen,
  output mac_slice_pkg::rx_frame_s rxFrame,
  output mac_slice_pkg::tx_frame_s txFrame
);
  initial begin
    rxFrame = '0;
    txFrame = '0;
  end
  // One frame verdict; fields are scrambled once the pulse ends.
  task automatic rx(input logic bad, input logic [2:0] mod);
    @(posedge clk);
    rxFrame <= '{done: 1'b1, fcsBad: bad, bitsMod: mod};
    @(posedge clk);
    rxFrame <= '{done: 1'b0, fcsBad: ~bad, bitsMod: ~mod};
  endtask : rx
  // One packet; a new start waits for the gap to open.
  task automatic tx(input int len);
    int k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (txGapOpen !== 1'b1 && k < 500);
    txFrame <= '{start: 1'b1, stop: 1'b0};
    @(posedge clk);
    txFrame <= '0;
    repeat (len) @(posedge clk);
    txFrame <= '{start: 1'b0, stop: 1'b1};
    @(posedge clk);
    txFrame <= '0;
  endtask : tx
endmodule : phy_model

// ### testbench/mac_gap_stats_bench.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin \
  err_count++; $display("wrong value %s exp %h got %h", nm, exp, got); \
  end end
module mac_gap_stats_bench;
  // ---------------------------------------------------------------
  // Signals and tables.
  // ---------------------------------------------------------------
  localparam logic [15:0] NV = 16'hA55A; // Arbitrary station octets.
  logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, txGapOpen, irq, eSeen;
  logic [7:0] paddr = 8'h00, stationOctetSix, stationOctetFive;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q, e;
  logic [3:0] pstrb = 4'hF, rdLanes = 4'h3;
  mac_slice_pkg::rx_frame_s rxFrame;
  mac_slice_pkg::tx_frame_s txFrame;
  int err_count = 0, checked = 0, n;
  logic [7:0] base [3] = '{mac_slice_pkg::CRC_ERR_OFS,
    mac_slice_pkg::GAP_OFS, mac_slice_pkg::STATION_OFS};
  logic [31:0] msk [3] = '{32'h0000_FFFF, 32'h0000_007F, 32'h0000_FFFF};
  logic [3:0] fr [5] = '{4'h8, 4'hB, 4'h0, 4'h8, 4'hF}; // {bad, mod}.
  logic [31:0] md [3] = '{32'h0000_0001, 32'h0000_0000, 32'h0000_0001};
  logic [31:0] gf [3] = '{32'h0000_0015, 32'h0000_0012, 32'h0000_0000};
  int gn [3] = '{24, 24, 3}; // Expected gap in nibbles.
  always #50 clk = ~clk;
  mac_gap_stats #(.NIBBLE_CYCLES(1)) i_mac_gap_stats (
    .clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .rdLanes, .prdata, .pready, .pslverr, .rxFrame, .txFrame,
    .stationNv(NV), .txGapOpen, .stationOctetSix, .stationOctetFive,
    .irq);
  phy_model i_phy_model (.clk, .txGapOpen, .rxFrame, .txFrame);
  // ---------------------------------------------------------------
  // Bus tasks; a lost pready ends the run.
  // ---------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int k = 0;
    @(posedge clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (k >= 16) begin
      err_count++;
      conclude();
    end
    q = prdata;
    eSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic al(input int i, input logic [3:0] o, input logic [31:0] d);
    apb(1'b1, base[i] + {4'h0, o}, d, 4'h3);
  endtask : al
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    conclude();
  end
  // ---------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    apb(1'b0, base[1], 32'h0000_0000, 4'hF);
    `CHK("gap reset", 32'h0000_0012, q)
    `CHK("octets", NV, {stationOctetSix, stationOctetFive})
    $display("test reset done");
    rdLanes <= 4'h0;
    for (int i = 0; i < 3; i++) begin
      al(i, mac_slice_pkg::ALIAS_CLR_OFS, 32'h0000_FFFF);
      al(i, mac_slice_pkg::ALIAS_SET_OFS, 32'h0000_00F3);
      al(i, mac_slice_pkg::ALIAS_CLR_OFS, 32'h0000_0031);
      al(i, mac_slice_pkg::ALIAS_INV_OFS, 32'h0000_0105);
      apb(1'b0, base[i], 32'h0000_0000, 4'hF);
      e = ((32'h0000_00F3 & ~32'h0000_0031) ^ 32'h0000_0105) & msk[i];
      `CHK("alias", e, q)
    end
    `CHK("octets", e[15:0], {stationOctetSix, stationOctetFive})
    apb(1'b1, base[1], 32'h0000_0000, 4'h1);
    apb(1'b0, base[1], 32'h0000_0000, 4'hF);
    `CHK("byte write", 32'h0000_0047, q)
    apb(1'b1, base[1], 32'hFFFF_FFFF, 4'hF);
    apb(1'b0, base[1], 32'h0000_0000, 4'hF);
    `CHK("gap upper", 32'h0000_007F, q)
    $display("test registers done");
    al(0, mac_slice_pkg::ALIAS_CLR_OFS, 32'h0000_FFFF);
    for (int i = 0; i < 5; i++) i_phy_model.rx(fr[i][3], fr[i][2:0]);
    i_phy_model.tx(6);
    apb(1'b0, base[0], 32'h0000_0000, 4'hF);
    `CHK("count", 32'h0000_0002, q)
    rdLanes <= 4'h3;
    apb(1'b0, base[0], 32'h0000_0000, 4'hF);
    `CHK("count", 32'h0000_0002, q)
    apb(1'b0, base[0], 32'h0000_0000, 4'hF);
    `CHK("cleared", 32'h0000_0000, q)
    $display("test counter done");
    apb(1'b1, mac_slice_pkg::INT_STAT_OFS, 32'h0000_0003, 4'hF);
    apb(1'b1, mac_slice_pkg::INT_MASK_OFS, 32'h0000_0001, 4'hF);
    `CHK("irq idle", 1'b0, irq)
    i_phy_model.rx(1'b1, 3'h0);
    repeat (5) @(posedge clk);
    `CHK("irq raised", 1'b1, irq)
    apb(1'b1, mac_slice_pkg::INT_STAT_OFS, 32'h0000_0001, 4'hF);
    repeat (3) @(posedge clk);
    `CHK("irq cleared", 1'b0, irq)
    apb(1'b1, mac_slice_pkg::INT_MASK_OFS, 32'h0000_0000, 4'hF);
    i_phy_model.rx(1'b1, 3'h0);
    repeat (5) @(posedge clk);
    `CHK("irq masked", 1'b0, irq)
    apb(1'b0, 8'h3C, 32'h0000_0000, 4'hF);
    `CHK("unmapped", 33'h1_0000_0000, {eSeen, q})
    $display("test interrupt done");
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, mac_slice_pkg::MODE_OFS, md[i], 4'hF);
      apb(1'b1, base[1], gf[i], 4'hF);
      i_phy_model.tx(6);
      n = 0;
      while (txGapOpen !== 1'b1 && n < 200) begin
        @(posedge clk);
        n++;
      end
      `CHK("gap", 1'b1, n >= gn[i] && n <= gn[i] + 6)
    end
    $display("test gap done");
    conclude();
  end
endmodule : mac_gap_stats_bench
